// ==== logic/fsp_defs.vh ====
// constants for the flash status poller: register map, fields, commands, timing
// assumes a 25 MHz core clock and an 8-bit parallel flash on the far side
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH

// register byte addresses on the software port
`define FSP_REG_CTRL      5'h00
`define FSP_REG_ADDR      5'h04
`define FSP_REG_STATUS    5'h08
`define FSP_REG_IRQ_STAT  5'h0c
`define FSP_REG_IRQ_MASK  5'h10
`define FSP_REG_DATA      5'h14

// control register fields (start and abort are self-clearing strobes)
`define FSP_CTRL_START    0
`define FSP_CTRL_ABORT    1
`define FSP_CTRL_CE_DELIM 2
`define FSP_CTRL_SECTOR   3
`define FSP_CTRL_RESET    4'h0

// status register fields
`define FSP_ST_BUSY       0
`define FSP_ST_DONE       1
`define FSP_ST_FAIL       2
`define FSP_ST_ABORTED    3
`define FSP_ST_ERR_SEEN   4
`define FSP_ST_BYTE_LSB   8

// interrupt bits
`define FSP_IRQ_DONE      0
`define FSP_IRQ_FAIL      1
`define FSP_IRQ_ABORT     2
`define FSP_IRQ_W         3

// status byte positions on the flash data bus
`define FSP_POLL_BIT      7
`define FSP_GTOGGLE_BIT   6
`define FSP_LIMIT_ERR_BIT 5
`define FSP_ERASE_ST_BIT  3
`define FSP_STOGGLE_BIT   2

// command that returns the flash to array reading
`define FSP_CMD_RESET     8'hf0

// timing: figures in ns, cycle counts derived (least times round up)
`define FSP_CLK_NS        40
`define FSP_T_ACC_NS      90
`define FSP_T_WP_NS       35
`define FSP_T_HIGH_NS     20
`define FSP_ACC_CYC  ((`FSP_T_ACC_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_WP_CYC   ((`FSP_T_WP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_HIGH_CYC ((`FSP_T_HIGH_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

`endif

// ==== logic/fsp_poller.v ====
// flash status poller: runs the toggle-bit algorithm against a parallel flash
// that is busy with an embedded program or erase, and reports the outcome.
// assumes the flash pins are synchronous to core_clk and that software has
// already issued the program or erase command sequence before starting.
//
// Functional notes
// RL1: device toggle status valid after final write
// RL2: sector toggle flips only in erasing sectors; the flash model flips it at every address in mode 1
// RL3: read cycles delimited by output enable or chip
// RL4: general toggle flips only during active erase; the flash model also flips it while programming, in modes 0 and 2
// RL5: general toggle complements each busy read
// RL6: general toggle steady after completion or suspend
// RL7: host starts with two consecutive full reads
// RL8: no toggle means done; next read gives data
// RL9: toggling then error high: recheck two reads
// RL10: still toggling after error: fail, send reset
// RL11: leaving polling restarts from first read pair
// RL12: device error bit high on limit exceeded
// RL13: erase started bit one once erase begins; the flash model sets it in mode 1 only, not in suspend
// RL14: after erase start only suspend accepted
// RL15: polling bit encodes program/erase/suspend state
// RL16: non-erasing sectors read array data in suspend
// RL17: second read pair guards against transitions
// RL18: protected program toggles briefly then stops
// RL19: device toggles once per read cycle falling edge

`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"

module fsp_poller (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [4:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    output reg         irq,
    output reg  [16:0] fl_addr,
    input  wire [7:0]  fl_dq_in,
    output reg  [7:0]  fl_dq_out,
    output reg         fl_dq_oe,
    output reg         fl_ce_n,
    output reg         fl_oe_n,
    output reg         fl_we_n
);

    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_RD   = 3'h1;
    localparam [2:0] S_GAP  = 3'h2;
    localparam [2:0] S_EVAL = 3'h3;
    localparam [2:0] S_WR   = 3'h4;
    localparam [2:0] S_WEND = 3'h5;

    localparam [2:0] P_R1    = 3'h0;
    localparam [2:0] P_R2    = 3'h1;
    localparam [2:0] P_R3    = 3'h2;
    localparam [2:0] P_R4    = 3'h3;
    localparam [2:0] P_FINAL = 3'h4;

    // counts fit in four bits; the cut from the integer value is deliberate
    localparam integer ACC_INT  = `FSP_ACC_CYC;
    localparam integer WP_INT   = `FSP_WP_CYC;
    localparam integer HIGH_INT = `FSP_HIGH_CYC;
    localparam [3:0]   ACC_CYC  = ACC_INT[3:0];
    localparam [3:0]   WP_CYC   = WP_INT[3:0];
    localparam [3:0]   HIGH_CYC = HIGH_INT[3:0];

    // one-hot interrupt events, in the layout of the status and mask registers
    localparam [`FSP_IRQ_W-1:0] EV_DONE  = 3'h1;
    localparam [`FSP_IRQ_W-1:0] EV_FAIL  = 3'h2;
    localparam [`FSP_IRQ_W-1:0] EV_ABORT = 3'h4;

    // the toggle bit under watch: sector bit tells which sector erases,
    // general bit tells active erase or program from suspend
    function tbit;
        input [7:0] b;
        input       sector;
        begin
            tbit = sector ? b[`FSP_STOGGLE_BIT] : b[`FSP_GTOGGLE_BIT];
        end
    endfunction

    // address decode shared by every register write
    function hit;
        input [4:0] a;
        input [4:0] r;
        begin
            hit = (a == r);
        end
    endfunction

    reg  [2:0]  state;
    reg  [2:0]  phase;
    reg  [3:0]  cnt;
    reg  [7:0]  first_byte;
    reg  [7:0]  last_byte;
    reg  [7:0]  array_data;
    reg         ce_delim;
    reg         sector_sel;
    reg  [16:0] poll_addr;
    reg         abort_pend;
    reg         busy;
    reg         done;
    reg         fail;
    reg         aborted;
    reg         err_seen;
    reg  [`FSP_IRQ_W-1:0] irq_stat;
    reg  [`FSP_IRQ_W-1:0] irq_mask;
    reg  [`FSP_IRQ_W-1:0] events;

    wire wr_ctrl = reg_wr && hit(reg_addr, `FSP_REG_CTRL);
    wire start   = wr_ctrl && reg_wdata[`FSP_CTRL_START] && !busy;
    // compared only inside a pair: reads one and two, or three and four
    wire toggled = tbit(first_byte, sector_sel) != tbit(last_byte, sector_sel);

    // configuration and address registers
    always @(posedge core_clk) begin
        if (!rst_n) begin
            ce_delim   <= 1'b0;
            sector_sel <= 1'b0;
            poll_addr  <= 17'h00000;
            irq_mask   <= {`FSP_IRQ_W{1'b0}};
        end else begin
            // frozen while busy so one poll never mixes watched bits or delimiters
            if (wr_ctrl && !busy) begin
                ce_delim   <= reg_wdata[`FSP_CTRL_CE_DELIM];
                sector_sel <= reg_wdata[`FSP_CTRL_SECTOR];
            end
            if (reg_wr && hit(reg_addr, `FSP_REG_ADDR) && !busy)
                poll_addr <= reg_wdata[16:0];
            if (reg_wr && hit(reg_addr, `FSP_REG_IRQ_MASK))
                irq_mask <= reg_wdata[`FSP_IRQ_W-1:0];
        end
    end

    // sticky interrupt status: a new event wins over a write-one clear
    always @(posedge core_clk) begin
        if (!rst_n) begin
            irq_stat <= {`FSP_IRQ_W{1'b0}};
            irq      <= 1'b0;
        end else begin
            if (reg_wr && hit(reg_addr, `FSP_REG_IRQ_STAT))
                irq_stat <= (irq_stat & ~reg_wdata[`FSP_IRQ_W-1:0]) | events;
            else
                irq_stat <= irq_stat | events;
            // registered, so irq trails the status bits by one cycle
            irq <= |(irq_stat & irq_mask);
        end
    end

    // read data stand in the cycle after the strobe only
    always @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `FSP_REG_CTRL:
                    reg_rdata <= {28'h0000000, sector_sel, ce_delim, 2'h0};
                `FSP_REG_ADDR:
                    reg_rdata <= {15'h0000, poll_addr};
                `FSP_REG_STATUS:
                    reg_rdata <= {16'h0000, last_byte, 3'h0, err_seen, aborted, fail,
                                  done, busy};
                `FSP_REG_IRQ_STAT:
                    reg_rdata <= {29'h00000000, irq_stat};
                `FSP_REG_IRQ_MASK:
                    reg_rdata <= {29'h00000000, irq_mask};
                `FSP_REG_DATA:
                    reg_rdata <= {24'h000000, array_data};
                default:
                    reg_rdata <= 32'h00000000;
            endcase
        end else begin
            // zero outside the answer cycle so stale data is never taken twice
            reg_rdata <= 32'h00000000;
        end
    end

    // polling sequencer
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state      <= S_IDLE;
            phase      <= P_R1;
            cnt        <= 4'h0;
            first_byte <= 8'h00;
            last_byte  <= 8'h00;
            array_data <= 8'h00;
            abort_pend <= 1'b0;
            busy       <= 1'b0;
            done       <= 1'b0;
            fail       <= 1'b0;
            aborted    <= 1'b0;
            err_seen   <= 1'b0;
            events     <= {`FSP_IRQ_W{1'b0}};
            fl_addr    <= 17'h00000;
            fl_dq_out  <= 8'h00;
            fl_dq_oe   <= 1'b0;
            fl_ce_n    <= 1'b1;
            fl_oe_n    <= 1'b1;
            fl_we_n    <= 1'b1;
        end else begin
            events <= {`FSP_IRQ_W{1'b0}};
            // an abort asked for outside a poll is dropped
            if (wr_ctrl && reg_wdata[`FSP_CTRL_ABORT] && busy)
                abort_pend <= 1'b1;
            case (state)
                S_IDLE: begin
                    // every enable high between polls leaves the flash in standby
                    fl_ce_n  <= 1'b1;
                    fl_oe_n  <= 1'b1;
                    fl_we_n  <= 1'b1;
                    fl_dq_oe <= 1'b0;
                    if (start) begin
                        // every start opens with a fresh first pair
                        busy       <= 1'b1; // RL11
                        done       <= 1'b0;
                        fail       <= 1'b0;
                        aborted    <= 1'b0;
                        err_seen   <= 1'b0;
                        abort_pend <= 1'b0;
                        phase      <= P_R1; // RL7
                        fl_addr    <= poll_addr;
                        fl_ce_n    <= 1'b0;
                        fl_oe_n    <= 1'b0;
                        cnt        <= ACC_CYC;
                        state      <= S_RD;
                    end
                end
                S_RD: begin
                    // hold both enables low through the access time
                    fl_ce_n <= 1'b0;
                    fl_oe_n <= 1'b0;
                    if (cnt == 4'h1) begin
                        last_byte <= fl_dq_in;
                        state     <= S_EVAL;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_EVAL: begin
                    // end the read cycle on the chosen enable; the other stays low
                    fl_ce_n <= ce_delim; // RL3
                    fl_oe_n <= ~ce_delim; // RL3
                    cnt     <= HIGH_CYC;
                    state   <= S_GAP;
                    case (phase)
                        P_R1: begin
                            first_byte <= last_byte;
                            phase      <= P_R2;
                        end
                        P_R2: begin
                            if (!toggled) begin
                                phase <= P_FINAL; // RL8
                            end else if (last_byte[`FSP_LIMIT_ERR_BIT]) begin
                                err_seen <= 1'b1;
                                phase    <= P_R3; // RL9
                            end else if (abort_pend) begin
                                // abort lands only between pairs, never inside a read
                                aborted <= 1'b1;
                                busy    <= 1'b0;
                                events  <= EV_ABORT;
                                fl_ce_n <= 1'b1;
                                fl_oe_n <= 1'b1;
                                state   <= S_IDLE;
                            end else begin
                                phase <= P_R1;
                            end
                        end
                        P_R3: begin
                            // the first pair may have caught status mid-change
                            first_byte <= last_byte; // RL17
                            phase      <= P_R4;
                        end
                        P_R4: begin
                            if (!toggled) begin
                                phase <= P_FINAL; // RL8
                            end else begin
                                // operation failed: put the reset command out
                                fl_ce_n   <= 1'b1;
                                fl_oe_n   <= 1'b1;
                                fl_dq_out <= `FSP_CMD_RESET; // RL10
                                state     <= S_WEND;
                            end
                        end
                        P_FINAL: begin
                            // the flash stopped toggling, so this read is array data
                            array_data <= last_byte; // RL8
                            done       <= 1'b1;
                            busy       <= 1'b0;
                            events     <= EV_DONE;
                            fl_ce_n    <= 1'b1;
                            fl_oe_n    <= 1'b1;
                            state      <= S_IDLE;
                        end
                        default: begin
                            phase <= P_R1;
                        end
                    endcase
                end
                S_GAP: begin
                    // the delimiting enable high here lets the flash count the next falling edge as a new read
                    if (cnt == 4'h1) begin
                        fl_ce_n <= 1'b0;
                        fl_oe_n <= 1'b0;
                        cnt     <= ACC_CYC;
                        state   <= S_RD;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_WEND: begin
                    // one idle cycle lets the flash release the bus first
                    fl_dq_oe <= 1'b1;
                    fl_ce_n  <= 1'b0;
                    fl_we_n  <= 1'b0;
                    cnt      <= WP_CYC;
                    state    <= S_WR;
                end
                S_WR: begin
                    if (cnt == 4'h1) begin
                        fl_we_n  <= 1'b1;
                        fl_ce_n  <= 1'b1;
                        fl_dq_oe <= 1'b0;
                        // the flash is back to array reads, but the operation failed
                        fail     <= 1'b1; // RL10
                        busy     <= 1'b0;
                        events   <= EV_FAIL;
                        state    <= S_IDLE;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule // fsp_poller

`default_nettype wire

// ==== sim/fsp_flash_model.sv ====
// flash model that answers status polls during embedded operations
// assumes its pins change just after core_clk edges
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_flash_model #(parameter logic [7:0] ARRAY = 8'ha5) (
    input  wire logic       core_clk,
    input  wire logic       fl_ce_n,
    input  wire logic       fl_oe_n,
    input  wire logic       fl_we_n,
    input  wire logic [16:0] fl_addr,
    input  wire logic       fl_dq_oe,
    input  wire logic [7:0] fl_dq_out,
    input  wire logic [1:0] mode,
    input  wire logic       load,
    input  wire logic [7:0] busy_n,
    output logic      [7:0] fl_dq_in,
    output logic      [7:0] reads,
    output logic            got_reset
);
    // mode 0 program, 1 erase, 2 program past its limit, 3 erase suspended
    logic [7:0] left, last, st;
    logic       tog, rd_q;
    wire        rd = !fl_ce_n && !fl_oe_n;
    assign st = {mode == 2'd3 || (mode != 2'd1 && !ARRAY[7]), mode != 2'd3 && tog,
                 mode == 2'd2, 1'b0, mode == 2'd1, mode[0] && tog, 2'b00};
    // a released bus shows the inverse of the last byte so stale data never matches
    // the top sector is told apart in suspend only, where the others read array data; in mode 1 every sector reads status
    wire        in_erase = mode != 2'd3 || fl_addr[16:14] == 3'h7;
    assign fl_dq_in = rd ? (left != 8'h00 && in_erase ? st : ARRAY) : ~last;
    always_ff @(posedge core_clk) begin
        rd_q <= rd;
        if (rd) last <= fl_dq_in;
        if (load) begin
            left <= busy_n;
            tog <= 1'b0;
            last <= 8'h00;
            reads <= 8'h00;
            got_reset <= 1'b0;
        end else begin
            if (rd && !rd_q) reads <= reads + 8'h01;
            if (rd && !rd_q && left != 8'h00) tog <= ~tog;
            // outside mode 2, toggling stops after a set number of reads with the data unchanged
            if (!rd && rd_q && left != 8'h00 && mode != 2'd2) left <= left - 8'h01;
            // an erase in progress ignores everything but suspend
            if (!fl_we_n && !fl_ce_n && fl_dq_oe && fl_dq_out == `FSP_CMD_RESET
                && mode != 2'd1) begin
                left <= 8'h00;
                got_reset <= 1'b1;
            end
        end
    end
endmodule // fsp_flash_model
`default_nettype wire

// ==== sim/fsp_poller_assertions.sv ====
// concurrent checks on the poller's software port and flash pins
// assumes one clock domain and rst_n synchronous active low
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_poller_assertions (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [4:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq,
    input wire logic [16:0] fl_addr,
    input wire logic [7:0]  fl_dq_in,
    input wire logic [7:0]  fl_dq_out,
    input wire logic        fl_dq_oe,
    input wire logic        fl_ce_n,
    input wire logic        fl_oe_n,
    input wire logic        fl_we_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire rd_n = fl_ce_n | fl_oe_n;
    // idle excludes every cycle from the setup of the reset command on, while fl_dq_out still holds it
    wire idle = fl_ce_n & fl_oe_n & fl_we_n & (fl_dq_out != `FSP_CMD_RESET);
    reset_cmd_a: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe
        && fl_dq_out == `FSP_CMD_RESET) else $error("bad reset command cycle");
    write_pulse_a: assert property ($fell(fl_we_n) |=> fl_we_n)
        else $error("write pulse not one cycle");
    read_access_a: assert property ($fell(rd_n) |-> !rd_n [*4] ##1 rd_n)
        else $error("read not four cycles low");
    read_gap_a: assert property ($rose(rd_n) && !(fl_ce_n && fl_oe_n) |=> !rd_n)
        else $error("delimiting gap not one cycle");
    no_clash_a: assert property (!fl_oe_n |-> !fl_dq_oe)
        else $error("data driven during a read");
    addr_hold_a: assert property (!rd_n && $past(!rd_n) |-> $stable(fl_addr))
        else $error("address moved during a read");
    start_read_a: assert property (idle && reg_wr && reg_addr == `FSP_REG_CTRL
        && reg_wdata[0] |=> !fl_ce_n && !fl_oe_n) else $error("start opened no read");
    irq_clear_a: assert property (idle && reg_wr && reg_addr == `FSP_REG_IRQ_STAT
        && reg_wdata[2:0] == 3'h7 |-> ##2 !irq) else $error("irq not cleared");
endmodule // fsp_poller_assertions
bind fsp_poller fsp_poller_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .fl_addr(fl_addr), .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n));
`default_nettype wire

// ==== sim/fsp_poller_tb.sv ====
// self-checking bench: poller against the flash model, one task per scenario
// assumes fsp_defs.vh on the include path and the checker bound in its own file
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.vh"
module fsp_poller_tb;
    logic        core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, load = 1'b1;
    logic [4:0]  reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [16:0] fl_addr;
    logic [7:0]  fl_dq_in, fl_dq_out, reads, busy_n = 8'h00;
    logic        irq, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, got_reset;
    logic [1:0]  mode = 2'd0;
    integer      num_errors = 0, checks_done = 0, cycles = 0;
    always #20 core_clk = ~core_clk;
    fsp_poller uut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .fl_addr(fl_addr), .fl_dq_in(fl_dq_in),
        .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n));
    fsp_flash_model flash (.core_clk(core_clk), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n), .fl_dq_oe(fl_dq_oe), .fl_dq_out(fl_dq_out), .mode(mode),
        .load(load), .busy_n(busy_n), .fl_dq_in(fl_dq_in), .reads(reads),
        .got_reset(got_reset), .fl_addr(fl_addr));
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // one quiet edge so a following call never re-raises the strobe in this step
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
    task automatic cmp_reg(input string what, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        cmp(what, exp, d);
    endtask
    task automatic run(input logic [1:0] m, input logic [7:0] n, input logic [31:0] ctl,
                       input logic [16:0] a);
        rst_n <= 1'b0;
        load <= 1'b1;
        mode <= m;
        busy_n <= n;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        load <= 1'b0;
        @(posedge core_clk);
        wr(`FSP_REG_IRQ_MASK, 32'h7);
        wr(`FSP_REG_ADDR, {15'h0, a});
        wr(`FSP_REG_CTRL, ctl);
        wr(`FSP_REG_CTRL, ctl | 32'h1);
        repeat (2) @(posedge core_clk);
        cmp("flash address", {15'h0, a}, {15'h0, fl_addr});
    endtask
    task automatic wait_idle;
        logic [31:0] d;
        d = 32'h1;
        for (int i = 0; i < 400 && d[0] !== 1'b0; i++) rd(`FSP_REG_STATUS, d);
    endtask
    task automatic check_done(input logic [7:0] n);
        wait_idle;
        cmp_reg("status", `FSP_REG_STATUS, 32'h0000a502);
        cmp_reg("array byte", `FSP_REG_DATA, 32'h000000a5);
        cmp("reads", {24'h0, n}, {24'h0, reads});
        cmp("irq", 32'h1, {31'h0, irq});
    endtask
    task automatic program_done;
        run(2'd0, 8'd4, 32'h0, 17'h1c000);
        check_done(8'd7);
        cmp_reg("irq status", `FSP_REG_IRQ_STAT, 32'h1);
        cmp_reg("unmapped", 5'h18, 32'h0);
        wr(`FSP_REG_IRQ_STAT, 32'h7);
        repeat (2) @(posedge core_clk);
        cmp("irq", 32'h0, {31'h0, irq});
    endtask
    task automatic erase_sector;
        run(2'd1, 8'd2, 32'hc, 17'h1c000);
        check_done(8'd5);
        cmp_reg("control", `FSP_REG_CTRL, 32'hc);
    endtask
    task automatic suspended;
        run(2'd3, 8'd2, 32'h0, 17'h1c000);
        check_done(8'd3);
        run(2'd3, 8'd2, 32'h8, 17'h1c000);
        check_done(8'd5);
        run(2'd3, 8'd2, 32'h8, 17'h04000);
        check_done(8'd3);
    endtask
    task automatic limit_fail;
        run(2'd2, 8'd1, 32'h0, 17'h1c000);
        wait_idle;
        cmp_reg("status", `FSP_REG_STATUS, 32'h00002014);
        cmp("reset sent", 32'h1, {31'h0, got_reset});
        cmp("reads", 32'h4, {24'h0, reads});
        cmp_reg("irq status", `FSP_REG_IRQ_STAT, 32'h2);
    endtask
    task automatic abort_poll;
        run(2'd0, 8'd200, 32'h0, 17'h1c000);
        wr(`FSP_REG_IRQ_MASK, 32'h0);
        wr(`FSP_REG_CTRL, 32'h2);
        wait_idle;
        cmp_reg("status", `FSP_REG_STATUS, 32'h00000008);
        cmp("whole pairs", 32'h0, {31'h0, reads[0]});
        cmp("irq", 32'h0, {31'h0, irq});
        wr(`FSP_REG_IRQ_MASK, 32'h4);
        repeat (2) @(posedge core_clk);
        cmp("irq", 32'h1, {31'h0, irq});
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        program_done;
        erase_sector;
        suspended;
        limit_fail;
        abort_poll;
        complete_run;
    end
    // the whole run needs a few hundred cycles
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run;
        end
    end
endmodule // fsp_poller_tb
`default_nettype wire
